// [rtl/bsd_pkg.sv]
// Package: constants, types and cell map of the boundary-scan data registers
package bsd_pkg;

  // ------------------------------------------------------------
  // Chain geometry
  // ------------------------------------------------------------
  localparam int BSR_LEN     = 84;
  localparam int IR_LEN      = 2;
  localparam int OE_GROUPS   = 5;
  localparam int SYNC_STAGES = 2;

  // ------------------------------------------------------------
  // Cell map (cell number == index into pin vectors)
  // ------------------------------------------------------------
  localparam int CELL_FRAME_GROUP_B_LO = 0;
  localparam int CELL_FRAME_GROUP_A_LO = 12;
  localparam int CELL_BUS_OUT_LO       = 24;
  localparam int CELL_BUS_OUT_HI       = 31;
  localparam int CELL_BUS_OUT_OE       = 32;
  localparam int CELL_BUS_IN_LO        = 33;
  localparam int CELL_BUS_IN_HI        = 40;
  localparam int CELL_BUS_IN_OE        = 41;
  localparam int CELL_BUS_CLK_LO       = 42;
  localparam int CELL_BUS_CLK_OE       = 46;
  localparam int CELL_LOCAL_FRAME      = 47;
  localparam int CELL_LOCAL_CLK_8MHZ   = 48;
  localparam int CELL_LOCAL_CLK_4MHZ   = 49;
  localparam int CELL_LOCAL_CLK_2MHZ   = 50;
  localparam int CELL_CONTROL_OUT      = 51;
  localparam int CELL_OUT_ONLY_OE      = 52;
  localparam int CELL_EXT_8K_REF_A     = 53;
  localparam int CELL_EXT_8K_REF_B     = 54;
  localparam int CELL_DATA_BUS_LO      = 63;
  localparam int CELL_DATA_BUS_OE      = 71;
  localparam int CELL_STROBE_LO        = 76;
  localparam int CELL_XFER_ACK_HI      = 83;

  // Output-enable groups: pin_oe bit number
  localparam int OE_BUS_OUT  = 0;
  localparam int OE_BUS_IN   = 1;
  localparam int OE_OUT_ONLY = 2;
  localparam int OE_DATA_BUS = 3;
  localparam int OE_BUS_CLK  = 4;
  localparam int OE_CELL [OE_GROUPS] = '{CELL_BUS_OUT_OE, CELL_BUS_IN_OE,
                                         CELL_OUT_ONLY_OE, CELL_DATA_BUS_OE,
                                         CELL_BUS_CLK_OE};

  // ------------------------------------------------------------
  // Instructions
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    BSD_IR_EXTEST          = 2'b00,
    BSD_IR_SAMPLE          = 2'b01,
    BSD_IR_BYPASS_TEST     = 2'b10,
    BSD_IR_BYPASS_WITHOUT  = 2'b11
  } bsd_ir_t;
  localparam logic [1:0] IR_CAPTURE_VAL = 2'b01;

  // ------------------------------------------------------------
  // Test access port states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET      = 4'h0, TAP_IDLE       = 4'h1,
    TAP_SEL_DR     = 4'h2, TAP_CAPTURE_DR = 4'h3,
    TAP_SHIFT_DR   = 4'h4, TAP_EXIT1_DR   = 4'h5,
    TAP_PAUSE_DR   = 4'h6, TAP_EXIT2_DR   = 4'h7,
    TAP_UPDATE_DR  = 4'h8, TAP_SEL_IR     = 4'h9,
    TAP_CAPTURE_IR = 4'ha, TAP_SHIFT_IR   = 4'hb,
    TAP_EXIT1_IR   = 4'hc, TAP_PAUSE_IR   = 4'hd,
    TAP_EXIT2_IR   = 4'he, TAP_UPDATE_IR  = 4'hf
  } bsd_tap_t;

  // ------------------------------------------------------------
  // Register map (AXI4-Lite byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [0:0] CTRL_RESET_VAL = 1'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : bsd_pkg

// [rtl/bsd_scan_regs.sv]
// Boundary-scan and bypass data registers with test port and register slave
//
// Behaviour
// - Two data registers: boundary chain, bypass
// - Bypass is one shift stage
// - Cells sit between core and every pin
// - Boundary chain holds 84 cells, 0..83
// - Cell 0 leaves first, ascending order
// - Tristate-enable cells active high
// - All-zero chain floats every output
// - Cells 24-31 bus outputs, 32 enables
// - Cells 33-40 bus inputs, 41 enables
// - Cells 47-51 frame, local clocks, control
// - Cell 52 enables all output-only pins
// - Cells 63-70 data bus, 71 enables
// - Cells 76-83 strobes, address, acknowledges
// - Extest: chain selected, pins from cells
// - Bypass-with-test: bypass selected, pins from cells
// - Output on falling edge, idle when not shifting
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
module bsd_scan_regs
  import bsd_pkg::*;
#(
  parameter int N_CELLS = bsd_pkg::BSR_LEN,
  parameter int ADDR_W  = 8
) (
  // Clock, reset, enable
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  // Test access port pins
  input  wire logic                tck,
  input  wire logic                tms,
  input  wire logic                tdi,
  output logic                     tdo,
  output logic                     tdo_oe,
  // Core side and pin side of the cells
  input  wire logic [N_CELLS-1:0]  core_value,
  input  wire logic [bsd_pkg::OE_GROUPS-1:0] core_oe,
  input  wire logic [N_CELLS-1:0]  pin_in,
  output logic      [N_CELLS-1:0]  pin_value,
  output logic      [bsd_pkg::OE_GROUPS-1:0] pin_oe,
  output logic                     test_mode,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import bsd_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers and test clock edges
  // ------------------------------------------------------------
  logic [N_CELLS+2:0] sync_q;
  logic               tck_s, tms_s, tdi_s;
  logic [N_CELLS-1:0] pin_in_s;
  logic               tck_d_r;
  logic               tck_rise, tck_fall;

  bsd_sync #(.W(N_CELLS+3)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({tck, tms, tdi, pin_in}),
    .q       (sync_q)
  );

  assign tck_s    = sync_q[N_CELLS+2];
  assign tms_s    = sync_q[N_CELLS+1];
  assign tdi_s    = sync_q[N_CELLS];
  assign pin_in_s = sync_q[N_CELLS-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tck_d_r <= 1'b0;
    end else if (ce) begin
      tck_d_r <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;

  // ------------------------------------------------------------
  // Test access port state machine
  // ------------------------------------------------------------
  bsd_tap_t state_r;
  bsd_tap_t state_nxt;
  logic     force_reset_r;

  always_comb begin
    case (state_r)
      TAP_RESET:      state_nxt = tms_s ? TAP_RESET     : TAP_IDLE;
      TAP_IDLE:       state_nxt = tms_s ? TAP_SEL_DR    : TAP_IDLE;
      TAP_SEL_DR:     state_nxt = tms_s ? TAP_SEL_IR    : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR: state_nxt = tms_s ? TAP_EXIT1_DR  : TAP_SHIFT_DR;
      TAP_SHIFT_DR:   state_nxt = tms_s ? TAP_EXIT1_DR  : TAP_SHIFT_DR;
      TAP_EXIT1_DR:   state_nxt = tms_s ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR:   state_nxt = tms_s ? TAP_EXIT2_DR  : TAP_PAUSE_DR;
      TAP_EXIT2_DR:   state_nxt = tms_s ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR:  state_nxt = tms_s ? TAP_SEL_DR    : TAP_IDLE;
      TAP_SEL_IR:     state_nxt = tms_s ? TAP_RESET     : TAP_CAPTURE_IR;
      TAP_CAPTURE_IR: state_nxt = tms_s ? TAP_EXIT1_IR  : TAP_SHIFT_IR;
      TAP_SHIFT_IR:   state_nxt = tms_s ? TAP_EXIT1_IR  : TAP_SHIFT_IR;
      TAP_EXIT1_IR:   state_nxt = tms_s ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR:   state_nxt = tms_s ? TAP_EXIT2_IR  : TAP_PAUSE_IR;
      TAP_EXIT2_IR:   state_nxt = tms_s ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR:  state_nxt = tms_s ? TAP_SEL_DR    : TAP_IDLE;
      default:        state_nxt = TAP_RESET;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= TAP_RESET;
    end else if (ce) begin
      if (force_reset_r) begin
        state_r <= TAP_RESET;
      end else if (tck_rise) begin
        state_r <= state_nxt;
      end
    end
  end

  // ------------------------------------------------------------
  // Instruction register
  // ------------------------------------------------------------
  bsd_ir_t          ir_r;
  logic [IR_LEN-1:0] ir_sh_r;
  logic             sel_bsr, pins_from_cells;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_r    <= BSD_IR_BYPASS_WITHOUT;
      ir_sh_r <= '0;
    end else if (ce) begin
      if (state_r == TAP_RESET) begin
        ir_r <= BSD_IR_BYPASS_WITHOUT;
      end else if (tck_rise && state_r == TAP_UPDATE_IR) begin
        ir_r <= bsd_ir_t'(ir_sh_r);
      end
      if (tck_rise && state_r == TAP_CAPTURE_IR) begin
        ir_sh_r <= IR_CAPTURE_VAL;
      end else if (tck_rise && state_r == TAP_SHIFT_IR) begin
        ir_sh_r <= {tdi_s, ir_sh_r[IR_LEN-1:1]};
      end
    end
  end

  // Chain selected for extest and sample, bypass otherwise
  assign sel_bsr = (ir_r == BSD_IR_EXTEST) || (ir_r == BSD_IR_SAMPLE);
  assign pins_from_cells = (ir_r == BSD_IR_EXTEST) ||
                           (ir_r == BSD_IR_BYPASS_TEST);

  // ------------------------------------------------------------
  // Data registers
  // ------------------------------------------------------------
  logic [N_CELLS-1:0] bsr_sh_r;
  logic [N_CELLS-1:0] bsr_upd_r;
  logic               byp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bsr_sh_r <= '0;
    end else if (ce && tck_rise && sel_bsr) begin
      if (state_r == TAP_CAPTURE_DR) begin
        bsr_sh_r <= pin_in_s;
      end else if (state_r == TAP_SHIFT_DR) begin
        bsr_sh_r <= {tdi_s, bsr_sh_r[N_CELLS-1:1]};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bsr_upd_r <= '0;
    end else if (ce && tck_rise && sel_bsr && state_r == TAP_UPDATE_DR) begin
      bsr_upd_r <= bsr_sh_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byp_r <= 1'b0;
    end else if (ce && tck_rise && !sel_bsr) begin
      if (state_r == TAP_CAPTURE_DR) begin
        byp_r <= 1'b0;
      end else if (state_r == TAP_SHIFT_DR) begin
        byp_r <= tdi_s;
      end
    end
  end

  // ------------------------------------------------------------
  // Serial output on the falling test clock edge
  // ------------------------------------------------------------
  logic tdo_r, tdo_oe_r;
  logic shifting;

  assign shifting = (state_r == TAP_SHIFT_DR) || (state_r == TAP_SHIFT_IR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (ce && tck_fall) begin
      tdo_oe_r <= shifting;
      if (state_r == TAP_SHIFT_IR) begin
        tdo_r <= ir_sh_r[0];
      end else if (sel_bsr) begin
        tdo_r <= bsr_sh_r[0];
      end else begin
        tdo_r <= byp_r;
      end
    end
  end

  assign tdo    = tdo_r;
  assign tdo_oe = tdo_oe_r;

  // ------------------------------------------------------------
  // Pin drive: core or boundary cells
  // ------------------------------------------------------------
  logic [N_CELLS-1:0]   pin_value_r;
  logic [OE_GROUPS-1:0] pin_oe_r;
  logic                 test_mode_r;

  // Cell i drives pin i; the package maps the named groups
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_value_r <= '0;
      test_mode_r <= 1'b0;
    end else if (ce) begin
      test_mode_r <= pins_from_cells;
      pin_value_r <= pins_from_cells ? bsr_upd_r : core_value;
    end
  end

  // One enable cell per pin group, a one drives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe_r <= '0;
    end else if (ce) begin
      for (int g = 0; g < OE_GROUPS; g++) begin
        pin_oe_r[g] <= pins_from_cells ? bsr_upd_r[OE_CELL[g]] : core_oe[g];
      end
    end
  end

  assign pin_value = pin_value_r;
  assign pin_oe    = pin_oe_r;
  assign test_mode = test_mode_r;

  // ------------------------------------------------------------
  // AXI4-Lite slave: control and status
  // ------------------------------------------------------------
  logic        awready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r     <= 1'b0;
      bvalid_r      <= 1'b0;
      bresp_r       <= RESP_OKAY;
      force_reset_r <= CTRL_RESET_VAL;
    end else if (ce) begin
      awready_r <= s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
      if (awready_r) begin
        bvalid_r <= 1'b1;
        if (s_axi_awaddr == REG_CTRL) begin
          bresp_r <= RESP_OKAY;
          if (s_axi_wstrb[0]) begin
            force_reset_r <= s_axi_wdata[0];
          end
        end else if (s_axi_awaddr == REG_STATUS) begin
          bresp_r <= RESP_OKAY;
        end else begin
          bresp_r <= RESP_SLVERR;
        end
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= RESP_OKAY;
    end else if (ce) begin
      arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
      if (arready_r) begin
        rvalid_r <= 1'b1;
        rresp_r  <= RESP_OKAY;
        if (s_axi_araddr == REG_CTRL) begin
          rdata_r <= {31'h0, force_reset_r};
        end else if (s_axi_araddr == REG_STATUS) begin
          rdata_r <= {24'h0, tdo_oe_r, test_mode_r, ir_r, state_r};
        end else begin
          rdata_r <= 32'h0;
          rresp_r <= RESP_SLVERR;
        end
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = awready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_bypass_stage;
    @(posedge aclk) disable iff (!aresetn)
    (ce && tck_rise && !sel_bsr && state_r == TAP_SHIFT_DR) |=> byp_r == $past(tdi_s);
  endproperty
  a_bypass_stage: assert property (p_bypass_stage)
    else $error("bypass stage did not take the input bit");

  property p_chain_shift;
    @(posedge aclk) disable iff (!aresetn)
    (ce && tck_rise && sel_bsr && state_r == TAP_SHIFT_DR) |=>
      (bsr_sh_r[N_CELLS-2:0] == $past(bsr_sh_r[N_CELLS-1:1])) &&
      (bsr_sh_r[N_CELLS-1] == $past(tdi_s));
  endproperty
  a_chain_shift: assert property (p_chain_shift)
    else $error("chain did not shift toward cell 0");

  property p_out_on_fall;
    @(posedge aclk) disable iff (!aresetn)
    (tdo_r != $past(tdo_r)) || (tdo_oe_r != $past(tdo_oe_r)) |-> $past(tck_fall);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall)
    else $error("serial output changed away from a falling edge");

  property p_out_idle;
    @(posedge aclk) disable iff (!aresetn)
    (ce && tck_fall) |=> tdo_oe_r == $past(shifting);
  endproperty
  a_out_idle: assert property (p_out_idle)
    else $error("serial output enable wrong after falling edge");

  property p_reset_instr;
    @(posedge aclk) disable iff (!aresetn)
    (ce && state_r == TAP_RESET) |=> ir_r == BSD_IR_BYPASS_WITHOUT;
  endproperty
  a_reset_instr: assert property (p_reset_instr)
    else $error("test reset did not load bypass without test");

  property p_extest_pins;
    @(posedge aclk) disable iff (!aresetn)
    (ce && ir_r == BSD_IR_EXTEST) |=> test_mode_r && (pin_value_r == $past(bsr_upd_r));
  endproperty
  a_extest_pins: assert property (p_extest_pins)
    else $error("extest pins not taken from cells");

  property p_bypass_test;
    @(posedge aclk) disable iff (!aresetn)
    (ce && ir_r == BSD_IR_BYPASS_TEST) |-> !sel_bsr ##1 (pin_value_r == $past(bsr_upd_r));
  endproperty
  a_bypass_test: assert property (p_bypass_test)
    else $error("bypass with test selection or pins wrong");

  property p_bus_out_oe;
    @(posedge aclk) disable iff (!aresetn)
    (ce && pins_from_cells) |=> pin_oe_r[OE_BUS_OUT] == $past(bsr_upd_r[CELL_BUS_OUT_OE]);
  endproperty
  a_bus_out_oe: assert property (p_bus_out_oe)
    else $error("bus output enable not from its cell");

  property p_bus_in_oe;
    @(posedge aclk) disable iff (!aresetn)
    (ce && pins_from_cells) |=> pin_oe_r[OE_BUS_IN] == $past(bsr_upd_r[CELL_BUS_IN_OE]);
  endproperty
  a_bus_in_oe: assert property (p_bus_in_oe)
    else $error("bus input enable not from its cell");

  property p_out_only_oe;
    @(posedge aclk) disable iff (!aresetn)
    (ce && pins_from_cells) |=> pin_oe_r[OE_OUT_ONLY] == $past(bsr_upd_r[CELL_OUT_ONLY_OE]);
  endproperty
  a_out_only_oe: assert property (p_out_only_oe)
    else $error("output-only enable not from its cell");

  property p_data_oe;
    @(posedge aclk) disable iff (!aresetn)
    (ce && pins_from_cells) |=> pin_oe_r[OE_DATA_BUS] == $past(bsr_upd_r[CELL_DATA_BUS_OE]);
  endproperty
  a_data_oe: assert property (p_data_oe)
    else $error("data bus enable not from its cell");

  property p_all_off;
    @(posedge aclk) disable iff (!aresetn)
    (ce && pins_from_cells && bsr_upd_r == '0) |=> pin_oe_r == '0;
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("all-zero chain left an output enabled");

  c_extest: cover property (@(posedge aclk) disable iff (!aresetn)
    ir_r == BSD_IR_EXTEST && state_r == TAP_UPDATE_DR && tck_rise);
  c_bypass_shift: cover property (@(posedge aclk) disable iff (!aresetn)
    !sel_bsr && state_r == TAP_SHIFT_DR && tck_rise);
  c_ir_update: cover property (@(posedge aclk) disable iff (!aresetn)
    state_r == TAP_UPDATE_IR && tck_rise);
  c_axi_read: cover property (@(posedge aclk) disable iff (!aresetn)
    rvalid_r && s_axi_rready);

endmodule : bsd_scan_regs

// [rtl/bsd_sync.sv]
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
module bsd_sync #(
  parameter int W = 1
) (
  // Clock and control
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q_r    <= '0;
    end else if (ce) begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule : bsd_sync

// [tb/boundary_scan_data_registers_bench.sv]
// Self-checking bench for the boundary-scan data registers
`timescale 1ns/10ps
module boundary_scan_data_registers_bench;
  import bsd_pkg::*;
  logic        aclk, aresetn, ce, tck, tms, tdi, tdo, tdo_oe, test_mode;
  logic [83:0] core_value, pin_in, pin_value, q_pat, dout;
  logic [4:0]  core_oe, pin_oe, exp_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          error_cnt, total_checks;

  bsd_scan_regs i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_value(core_value), .core_oe(core_oe),
    .pin_in(pin_in), .pin_value(pin_value), .pin_oe(pin_oe), .test_mode(test_mode),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  bsd_test_ctrl i_jtag (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // Checks and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [83:0] e, input logic [83:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic over(input int n);
    if (n >= 100) begin
      error_cnt++;
      end_of_test();
    end
  endtask : over

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (awready !== 1'b1 && n < 100);
    over(n);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    over(n);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 100);
    over(n);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    over(n);
    rready <= 1'b0;
    d = rdata;
    chk("rresp", er, rresp);
  endtask : axi_rd

  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    ce = 1'b1;
    wstrb = 4'hf;
    core_value = 84'h9_3c5a_0ff0_1234_5678_9abc;
    core_oe = 5'h15;
    pin_in = 84'ha_5f00_c3c3_e1e1_7777_0f0f;
    q_pat = 84'h6_8421_0fed_cba9_8765_4321;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("pin_value normal", core_value, pin_value);
    chk("pin_oe normal", core_oe, pin_oe);
    chk("tdo_oe idle", 1'b0, tdo_oe);
    axi_rd(REG_STATUS, RESP_OKAY, rd);
    chk("status", 32'h30, rd);
    axi_rd(8'h08, RESP_SLVERR, rd);
    chk("unmapped", 32'h0, rd);
    i_jtag.scan(1'b1, 84'h0, 2, dout);
    i_jtag.scan(1'b0, q_pat, 84, dout);
    chk("chain capture", pin_in, dout);
    for (int g = 0; g < OE_GROUPS; g++) exp_oe[g] = q_pat[OE_CELL[g]];
    chk("pins extest", q_pat, pin_value);
    chk("oe extest", exp_oe, pin_oe);
    chk("test_mode extest", 1'b1, test_mode);
    i_jtag.scan(1'b1, 84'h2, 2, dout);
    i_jtag.scan(1'b0, 84'had, 8, dout);
    chk("bypass path", 84'h5a, dout);
    chk("pins bypass test", q_pat, pin_value);
    chk("test_mode bypass", 1'b1, test_mode);
    pin_in <= ~pin_in;
    i_jtag.scan(1'b1, 84'h0, 2, dout);
    i_jtag.scan(1'b0, 84'h0, 84, dout);
    chk("recapture", pin_in, dout);
    chk("all off oe", 5'h0, pin_oe);
    axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("test_mode forced", 1'b0, test_mode);
    chk("pins forced", core_value, pin_value);
    axi_rd(REG_STATUS, RESP_OKAY, rd);
    chk("status forced", 32'h30, rd);
    axi_rd(REG_CTRL, RESP_OKAY, rd);
    chk("ctrl readback", 32'h1, rd);
    // Clock enable low must hold every register
    ce <= 1'b0;
    core_value <= ~core_value;
    repeat (4) @(posedge aclk);
    chk("ce freeze", ~core_value, pin_value);
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("ce run", core_value, pin_value);
    axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
    // Sample: chain selected, pins stay with the core
    i_jtag.scan(1'b1, 84'h1, 2, dout);
    i_jtag.scan(1'b0, q_pat, 84, dout);
    chk("sample capture", pin_in, dout);
    chk("test_mode sample", 1'b0, test_mode);
    chk("pins sample", core_value, pin_value);
    axi_wr(8'h10, 32'h1, RESP_SLVERR);
    end_of_test();
  end
endmodule : boundary_scan_data_registers_bench

// [tb/bsd_test_ctrl.sv]
// Behavioural boundary-scan test controller on the test port
`timescale 1ns/10ps
module bsd_test_ctrl (
  // Test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // Released lines float high, clock stands low
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test clock of 400 ns
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #200 tck = 1'b1;
    // Undriven output reads as the inverse of its last value
    #190 q = tdo_oe ? tdo : ~tdo;
    #10 tck = 1'b0;
  endtask : step

  // Idle, scan n bits (instruction or data path), update, back to idle
  task automatic scan(input logic ir, input logic [83:0] din, input int n,
                      output logic [83:0] dout);
    logic q;
    dout = '0;
    #13;
    step(1'b0, 1'b1, q);
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    tms = 1'b1;
    tdi = 1'b1;
  endtask : scan
endmodule : bsd_test_ctrl
